// [include/qvp_defines.vh]
// register offsets, field positions, reset values and counts of the
// quiet voltage pwm block; included by the pwm core and its testbench, not by the period counter
`ifndef QVP_DEFINES_VH
`define QVP_DEFINES_VH

// ---------------------------------------------------------------
// register byte offsets (word aligned)
// ---------------------------------------------------------------
`define QVP_ADDR_W 4
`define QVP_OFS_CHOP 4'h0
`define QVP_OFS_PWM 4'h4
`define QVP_OFS_STATUS 4'h8

// ---------------------------------------------------------------
// chopper configuration fields
// ---------------------------------------------------------------
`define QVP_DRIVER_OFF_TIME_LSB 0
`define QVP_DRIVER_OFF_TIME_MSB 3
`define QVP_TBL_LSB 4
`define QVP_TBL_MSB 5
`define QVP_QEN_BIT 6
`define QVP_CHOP_RST 7'h00

// ---------------------------------------------------------------
// pwm configuration fields
// ---------------------------------------------------------------
`define QVP_OFFS_LSB 0
`define QVP_OFFS_MSB 7
`define QVP_GRAD_LSB 8
`define QVP_GRAD_MSB 15
`define QVP_FREQ_LSB 16
`define QVP_FREQ_MSB 17
`define QVP_AUTO_BIT 18
`define QVP_SYM_BIT 19
`define QVP_FW_LSB 20
`define QVP_FW_MSB 21
`define QVP_PWM_RST 22'h000000

// ---------------------------------------------------------------
// status fields
// ---------------------------------------------------------------
`define QVP_STAT_SCALE_MSB 7
`define QVP_STAT_ACT_BIT 8
`define QVP_STAT_REENT_BIT 9
`define QVP_STAT_DRV_BIT 10

// ---------------------------------------------------------------
// pwm periods in system clocks per divider code
// ---------------------------------------------------------------
`define QVP_CNT_W 11
`define QVP_PER0 11'd1024
`define QVP_PER1 11'd683
`define QVP_PER2 11'd512
`define QVP_PER3 11'd410

// ---------------------------------------------------------------
// comparator blank times in system clocks
// ---------------------------------------------------------------
`define QVP_BLK_W 6
`define QVP_BLK0 6'd16
`define QVP_BLK1 6'd24
`define QVP_BLK2 6'd32
`define QVP_BLK3 6'd40

// ---------------------------------------------------------------
// standstill coil options and scale limits
// ---------------------------------------------------------------
`define QVP_FW_NORMAL 2'h0
`define QVP_FW_FREE 2'h1
`define QVP_FW_LS 2'h2
`define QVP_FW_HS 2'h3
`define QVP_GRAD_MIN 8'h01
`define QVP_GRAD_MAX 8'h0F
`define QVP_SCALE_MAX 8'hFF
`define QVP_SCALE_RST 8'h00

`endif

// [src/qvp_period_counter.v]
// pwm period counter: counts 0 .. period-1 and flags cycle start and
// the half-period point
// assumes period is at least 2 and changes only between cycles matter
module qvp_period_counter #(
    parameter CW = 11
) (
    // clock and reset
    input wire i_clk,
    input wire i_arst_n,
    // period select
    input wire [CW-1:0] i_period,
    // count and markers
    output reg [CW-1:0] o_count,
    output wire o_cycle_start,
    output wire o_half
);

    wire [CW-1:0] last = i_period - {{(CW-1){1'b0}}, 1'b1};
    wire [CW-1:0] half = {1'b0, i_period[CW-1:1]};

    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_count <= {CW{1'b0}};
        end else if (o_count >= last) begin
            o_count <= {CW{1'b0}};
        end else begin
            o_count <= o_count + {{(CW-1){1'b0}}, 1'b1};
        end
    end

    assign o_cycle_start = (o_count == {CW{1'b0}});
    assign o_half = (o_count == half);

endmodule

// [src/qvp_pwm_core.v]
// quiet voltage pwm chopper core with wishbone classic register slave
// assumes velocity, current and mode inputs come from logic on i_clk;
// the comparator input is asynchronous and is synchronised here
//
// The Wishbone register port and the register addresses were chosen for this implementation.
`include "qvp_defines.vh"

module qvp_pwm_core (
    // clock and reset
    input wire i_clk,
    input wire i_arst_n,
    // wishbone classic slave
    input wire i_wb_cyc,
    input wire i_wb_stb,
    input wire i_wb_we,
    input wire [`QVP_ADDR_W-1:0] i_wb_adr,
    input wire [3:0] i_wb_sel,
    input wire [31:0] i_wb_dat,
    output reg [31:0] o_wb_dat,
    output reg o_wb_ack,
    // motion and regulation inputs
    input wire [7:0] i_velocity,
    input wire [7:0] i_current_meas,
    input wire [7:0] i_current_target,
    input wire i_standstill,
    input wire i_hold_zero,
    input wire i_other_mode,
    // current comparator
    input wire i_switch_event,
    input wire i_comparator,
    output reg o_comp_blank,
    output reg o_comp_valid,
    // power bridge control
    output reg [1:0] o_coil_hs,
    output reg [1:0] o_coil_ls,
    output reg o_pwm_cycle,
    output reg [7:0] o_pwm_scale
);

    // ---------------------------------------------------------------
    // configuration registers
    // ---------------------------------------------------------------
    reg [6:0] chop_conf;
    reg [21:0] pwm_conf;

    wire [3:0] driver_off_time = chop_conf[`QVP_DRIVER_OFF_TIME_MSB:`QVP_DRIVER_OFF_TIME_LSB];
    wire [1:0] comparator_blank_select =
        chop_conf[`QVP_TBL_MSB:`QVP_TBL_LSB];
    wire quiet_enable = chop_conf[`QVP_QEN_BIT];
    wire [7:0] amplitude_offset = pwm_conf[`QVP_OFFS_MSB:`QVP_OFFS_LSB];
    wire [7:0] amplitude_gradient = pwm_conf[`QVP_GRAD_MSB:`QVP_GRAD_LSB];
    wire [1:0] chopper_clock_divider_select =
        pwm_conf[`QVP_FREQ_MSB:`QVP_FREQ_LSB];
    wire autoscale = pwm_conf[`QVP_AUTO_BIT];
    wire symmetric = pwm_conf[`QVP_SYM_BIT];
    wire [1:0] standstill_coil_option = pwm_conf[`QVP_FW_MSB:`QVP_FW_LSB];

    wire driver_enable = (driver_off_time != 4'h0);
    wire quiet_active = quiet_enable & ~i_other_mode;
    wire reentry_ok;
    wire [31:0] status_word;

    // ---------------------------------------------------------------
    // wishbone slave: one wait state, ack for every address
    // ---------------------------------------------------------------
    wire wb_req = i_wb_cyc & i_wb_stb & ~o_wb_ack;
    wire wb_wr = wb_req & i_wb_we;
    reg [31:0] rd_mux;

    always @* begin
        case (i_wb_adr)
            `QVP_OFS_CHOP: rd_mux = {25'h0000000, chop_conf};
            `QVP_OFS_PWM: rd_mux = {10'h000, pwm_conf};
            `QVP_OFS_STATUS: rd_mux = status_word;
            default: rd_mux = 32'h00000000;
        endcase
    end

    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_wb_ack <= 1'b0;
            o_wb_dat <= 32'h00000000;
            chop_conf <= `QVP_CHOP_RST;
            pwm_conf <= `QVP_PWM_RST;
        end else begin
            o_wb_ack <= wb_req;
            if (wb_req && !i_wb_we) begin
                o_wb_dat <= rd_mux;
            end
            if (wb_wr && i_wb_adr == `QVP_OFS_CHOP && i_wb_sel[0]) begin
                chop_conf <= i_wb_dat[6:0];
            end
            if (wb_wr && i_wb_adr == `QVP_OFS_PWM) begin
                if (i_wb_sel[0]) begin
                    pwm_conf[7:0] <= i_wb_dat[7:0];
                end
                if (i_wb_sel[1]) begin
                    pwm_conf[15:8] <= i_wb_dat[15:8];
                end
                if (i_wb_sel[2]) begin
                    pwm_conf[21:16] <= i_wb_dat[21:16];
                end
            end
        end
    end

    // ---------------------------------------------------------------
    // pwm period from the divider select
    // ---------------------------------------------------------------
    reg [`QVP_CNT_W-1:0] period;
    wire [`QVP_CNT_W-1:0] pwm_count;
    wire cycle_start;
    wire half_point;

    always @* begin
        case (chopper_clock_divider_select)
            2'h0: period = `QVP_PER0;
            2'h1: period = `QVP_PER1;
            2'h2: period = `QVP_PER2;
            default: period = `QVP_PER3;
        endcase
    end

    qvp_period_counter #(
        .CW(`QVP_CNT_W)
    ) u_period (
        .i_clk(i_clk),
        .i_arst_n(i_arst_n),
        .i_period(period),
        .o_count(pwm_count),
        .o_cycle_start(cycle_start),
        .o_half(half_point)
    );

    // ---------------------------------------------------------------
    // amplitude: forward (velocity) or regulated scale
    // ---------------------------------------------------------------
    reg [7:0] loop_grad;
    wire [15:0] vel_prod = amplitude_gradient * i_velocity;
    wire [8:0] fwd_sum = {1'b0, amplitude_offset} + {1'b0, vel_prod[15:8]};
    wire [7:0] fwd_scale = fwd_sum[8] ? `QVP_SCALE_MAX : fwd_sum[7:0];
    wire [8:0] reg_up = {1'b0, o_pwm_scale} + {1'b0, loop_grad};
    wire [8:0] reg_dn = {1'b0, o_pwm_scale} - {1'b0, loop_grad};
    reg [7:0] next_scale;

    always @* begin
        if (amplitude_gradient < `QVP_GRAD_MIN) begin
            loop_grad = `QVP_GRAD_MIN;
        end else if (amplitude_gradient > `QVP_GRAD_MAX) begin
            loop_grad = `QVP_GRAD_MAX;
        end else begin
            loop_grad = amplitude_gradient;
        end
    end

    always @* begin
        next_scale = o_pwm_scale;
        if (!autoscale) begin
            next_scale = fwd_scale;
        end else if (i_current_meas < i_current_target) begin
            next_scale = reg_up[8] ? `QVP_SCALE_MAX : reg_up[7:0];
        end else if (i_current_meas > i_current_target) begin
            next_scale = reg_dn[8] ? `QVP_SCALE_RST : reg_dn[7:0];
        end
    end

    // scale moves once per pwm cycle and only in the quiet chopper
    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_pwm_scale <= `QVP_SCALE_RST;
        end else if (cycle_start && quiet_active) begin
            o_pwm_scale <= next_scale;
        end
    end

    assign reentry_ok = autoscale & (o_pwm_scale <= amplitude_offset);

    assign status_word = {21'h000000, driver_enable, reentry_ok,
                          quiet_active, o_pwm_scale};

    // ---------------------------------------------------------------
    // duty latch: symmetric updates at cycle start only
    // ---------------------------------------------------------------
    reg [7:0] duty;
    wire [`QVP_CNT_W+7:0] duty_prod = duty * period;
    wire [`QVP_CNT_W-1:0] duty_cnt = duty_prod[`QVP_CNT_W+7:8];

    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            duty <= `QVP_SCALE_RST;
        end else if (cycle_start || (half_point && !symmetric)) begin
            duty <= o_pwm_scale;
        end
    end

    // ---------------------------------------------------------------
    // bridge control with standstill options
    // ---------------------------------------------------------------
    wire pwm_on = (pwm_count < duty_cnt);
    wire park = i_standstill & i_hold_zero & quiet_enable;
    reg [1:0] next_hs;
    reg [1:0] next_ls;

    always @* begin
        next_hs = {2{pwm_on}};
        next_ls = {2{~pwm_on}};
        if (!driver_enable) begin
            next_hs = 2'h0;
            next_ls = 2'h0;
        end else if (park) begin
            case (standstill_coil_option)
                `QVP_FW_FREE: begin
                    next_hs = 2'h0;
                    next_ls = 2'h0;
                end
                `QVP_FW_LS: begin
                    next_hs = 2'h0;
                    next_ls = 2'h3;
                end
                `QVP_FW_HS: begin
                    next_hs = 2'h3;
                    next_ls = 2'h0;
                end
                default: begin
                    next_hs = {2{pwm_on}};
                    next_ls = {2{~pwm_on}};
                end
            endcase
        end
    end

    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_coil_hs <= 2'h0;
            o_coil_ls <= 2'h0;
            o_pwm_cycle <= 1'b0;
        end else begin
            o_coil_hs <= next_hs;
            o_coil_ls <= next_ls;
            o_pwm_cycle <= cycle_start & driver_enable;
        end
    end

    // ---------------------------------------------------------------
    // comparator synchroniser and blanking
    // ---------------------------------------------------------------
    reg comp_s1;
    reg comp_s2;
    reg [`QVP_BLK_W-1:0] blank_len;
    reg [`QVP_BLK_W-1:0] blank_cnt;

    always @* begin
        case (comparator_blank_select)
            2'h0: blank_len = `QVP_BLK0;
            2'h1: blank_len = `QVP_BLK1;
            2'h2: blank_len = `QVP_BLK2;
            default: blank_len = `QVP_BLK3;
        endcase
    end

    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            comp_s1 <= 1'b0;
            comp_s2 <= 1'b0;
            blank_cnt <= {`QVP_BLK_W{1'b0}};
            o_comp_blank <= 1'b0;
            o_comp_valid <= 1'b0;
        end else begin
            comp_s1 <= i_comparator;
            comp_s2 <= comp_s1;
            if (i_switch_event) begin
                blank_cnt <= blank_len;
            end else if (blank_cnt != {`QVP_BLK_W{1'b0}}) begin
                blank_cnt <= blank_cnt - {{(`QVP_BLK_W-1){1'b0}}, 1'b1};
            end
            o_comp_blank <= i_switch_event |
                            (blank_cnt > {{(`QVP_BLK_W-1){1'b0}}, 1'b1});
            o_comp_valid <= comp_s2 & ~i_switch_event &
                            (blank_cnt <= {{(`QVP_BLK_W-1){1'b0}}, 1'b1});
        end
    end

endmodule

// [testbench/qvp_bridge_model.sv]
// power bridge model: reports each gate change as a switch event
// assumes gate outputs registered on the same clock
module qvp_bridge_model (
    // clock and gates
    input wire logic i_clk,
    input wire logic [1:0] i_hs,
    input wire logic [1:0] i_ls,
    input wire logic i_kick,
    // sense
    output logic o_switch_event,
    output logic o_comparator
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] prev = 4'h0;
    initial o_comparator = 1'b0;
    // comparator toggles every cycle so blanking is visible
    always @(posedge i_clk) begin
        prev <= {i_hs, i_ls};
        o_comparator <= ~o_comparator;
    end
    assign o_switch_event = i_kick | (prev != {i_hs, i_ls});
endmodule

// [testbench/qvp_pwm_core_asserts.sv]
// checker of the pwm core ports
// assumes one clock and the active low asynchronous reset
module qvp_pwm_core_asserts (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_arst_n,
    // bus
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic o_wb_ack,
    // comparator and bridge
    input wire logic i_switch_event,
    input wire logic i_other_mode,
    input wire logic o_comp_blank,
    input wire logic o_comp_valid,
    input wire logic [1:0] o_coil_hs,
    input wire logic [1:0] o_coil_ls,
    input wire logic o_pwm_cycle,
    input wire logic [7:0] o_pwm_scale
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);
    logic [10:0] gap;
    logic [5:0] run;
    logic seen;
    // gap since last cycle start; a write voids the next measurement
    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            gap <= 11'h0;
            seen <= 1'b0;
            run <= 6'h0;
        end else begin
            gap <= o_pwm_cycle ? 11'h1 : gap + {10'h0, gap != 11'h7FF};
            seen <= (o_pwm_cycle | seen) & !(i_wb_cyc & i_wb_we);
            run <= !o_comp_blank ? 6'h0 : run + {5'h0, run != 6'h3F};
        end
    end
    sequence s_req;
        i_wb_cyc && i_wb_stb && !o_wb_ack;
    endsequence
    sequence s_ack_drop;
        o_wb_ack ##1 !o_wb_ack;
    endsequence
    a_ack_answer: assert property (s_req |=> s_ack_drop)
        else $error("no single ack after request");
    a_ack_cause: assert property (o_wb_ack |-> $past(i_wb_cyc & i_wb_stb))
        else $error("ack without request");
    a_cycle_pulse: assert property (o_pwm_cycle |=> !o_pwm_cycle)
        else $error("cycle start longer than one clock");
    a_cycle_period: assert property (o_pwm_cycle && seen |->
        gap inside {11'd410, 11'd512, 11'd683, 11'd1024})
        else $error("pwm period not a divider value");
    a_blank_start: assert property (i_switch_event |=> o_comp_blank)
        else $error("switch event not blanked");
    a_blank_min: assert property (run != 6'h0 && !o_comp_blank
        |-> run >= 6'd16)
        else $error("blank shorter than 16 clocks");
    a_valid_blank: assert property (o_comp_blank |-> !o_comp_valid)
        else $error("comparator valid while blanked");
    a_scale_frozen: assert property (i_other_mode && $past(i_other_mode)
        |-> $stable(o_pwm_scale))
        else $error("scale moved in other mode");
    a_no_shoot: assert property ((o_coil_hs & o_coil_ls) == 2'h0)
        else $error("high and low side on together");
endmodule
bind qvp_pwm_core qvp_pwm_core_asserts u_chk (.i_clk(i_clk),
    .i_arst_n(i_arst_n), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
    .i_wb_we(i_wb_we), .o_wb_ack(o_wb_ack),
    .i_switch_event(i_switch_event), .i_other_mode(i_other_mode),
    .o_comp_blank(o_comp_blank), .o_comp_valid(o_comp_valid),
    .o_coil_hs(o_coil_hs), .o_coil_ls(o_coil_ls),
    .o_pwm_cycle(o_pwm_cycle), .o_pwm_scale(o_pwm_scale));

// [testbench/qvp_pwm_core_test.sv]
// testbench of the pwm core: register model, periods, blanking,
// standstill options and amplitude scaling
// assumes one bus wait state and registered outputs
`include "qvp_defines.vh"
module qvp_pwm_core_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic i_clk = 1'b0, i_arst_n = 1'b0, cyc = 1'b0, stb = 1'b0;
    logic we = 1'b0, kick = 1'b0, stand = 1'b0, hzero = 1'b0;
    logic other = 1'b0, ack, blank, valid, pcyc, sw, comp;
    logic [1:0] hs, ls;
    logic [3:0] adr = 4'h0, sel = 4'h0;
    logic [7:0] vel = 8'h0, meas = 8'h0, targ = 8'h0, scale, s0;
    logic [31:0] wdat = 32'h0, seed = 32'hA8A7, q, rdat;
    int errors = 0, checks_done = 0, chop_m = 0, pwm_m = 0, n, i, e;
    int per[4] = '{1024, 683, 512, 410};
    qvp_pwm_core dut (.i_clk(i_clk), .i_arst_n(i_arst_n),
        .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr),
        .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
        .i_velocity(vel), .i_current_meas(meas), .i_current_target(targ),
        .i_standstill(stand), .i_hold_zero(hzero), .i_other_mode(other),
        .i_switch_event(sw), .i_comparator(comp), .o_comp_blank(blank),
        .o_comp_valid(valid), .o_coil_hs(hs), .o_coil_ls(ls),
        .o_pwm_cycle(pcyc), .o_pwm_scale(scale));
    qvp_bridge_model bridge (.i_clk(i_clk), .i_hs(hs), .i_ls(ls),
        .i_kick(kick), .o_switch_event(sw), .o_comparator(comp));
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic int mrg(int o, logic [31:0] d, logic [3:0] s);
        for (int k = 0; k < 4; k++)
            if (s[k])
                o[8*k +: 8] = d[8*k +: 8];
        return o;
    endfunction
    function automatic int fwd(int o, int g, int v);
        int f;
        f = o + ((g * v) >> 8);
        return f > 255 ? 255 : f;
    endfunction
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        checks_done++;
        if (g !== x) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, g, x);
        end
    endtask
    task automatic bus(input logic w, input logic [3:0] a,
                       input logic [31:0] d, input logic [3:0] s);
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= s;
        do begin
            @(posedge i_clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        q = rdat;
        if (n == 50)
            chk(0, 1);
        if (w && a == `QVP_OFS_CHOP)
            chop_m = mrg(chop_m, d, s) & 32'h7F;
        if (w && a == `QVP_OFS_PWM)
            pwm_m = mrg(pwm_m, d, s) & 32'h3FFFFF;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge i_clk);
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] x);
        bus(1'b0, a, 32'h0, 4'h0);
        chk(q, x);
    endtask
    task automatic gap();
        n = 0;
        do begin
            @(posedge i_clk);
            n++;
        end while (pcyc !== 1'b1 && n < 3000);
    endtask
    task automatic complete_run();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // ----------------------------------------------------------------
    // clock, timeout and sequence
    // ----------------------------------------------------------------
    initial forever #20 i_clk = ~i_clk;
    initial begin
        repeat (40000) @(posedge i_clk);
        errors++;
        complete_run();
    end
    initial begin
        repeat (2) @(posedge i_clk);
        i_arst_n <= 1'b1;
        rd(`QVP_OFS_CHOP, 0);
        rd(`QVP_OFS_STATUS, 0);
        bus(1'b1, 4'hC, 32'hFFFFFFFF, 4'hF);
        bus(1'b1, `QVP_OFS_STATUS, 32'hFFFFFFFF, 4'hF);
        rd(4'hC, 0);
        rd(`QVP_OFS_STATUS, 0);
        for (i = 0; i < 4; i++) begin
            e = rnd();
            bus(1'b1, `QVP_OFS_PWM, rnd(), e[3:0]);
            bus(1'b1, `QVP_OFS_CHOP, e & 32'h70, 4'hF);
            rd(`QVP_OFS_PWM, pwm_m);
            rd(`QVP_OFS_CHOP, chop_m);
        end
        bus(1'b1, `QVP_OFS_CHOP, 32'h41, 4'hF);
        for (i = 0; i < 4; i++) begin
            bus(1'b1, `QVP_OFS_PWM, i << 16, 4'hF);
            gap();
            gap();
            chk(n, per[i]);
        end
        bus(1'b1, `QVP_OFS_CHOP, 32'h4F, 4'hF);
        gap();
        gap();
        chk(n, 410);
        bus(1'b1, `QVP_OFS_CHOP, 32'h40, 4'hF);
        gap();
        chk(n, 3000);
        bus(1'b0, `QVP_OFS_STATUS, 32'h0, 4'h0);
        chk(q[10], 1'b0);
        for (i = 0; i < 4; i++) begin
            bus(1'b1, `QVP_OFS_CHOP, 32'h40 | (i << 4), 4'hF);
            kick <= 1'b1;
            @(posedge i_clk);
            kick <= 1'b0;
            e = 0;
            repeat (60) begin
                @(posedge i_clk);
                e += blank;
            end
            chk(e, 16 + 8 * i);
            e = 0;
            repeat (4) begin
                @(posedge i_clk);
                e += valid;
            end
            chk(e, 2);
        end
        stand <= 1'b1;
        hzero <= 1'b1;
        bus(1'b1, `QVP_OFS_CHOP, 32'h41, 4'hF);
        for (i = 1; i < 4; i++) begin
            bus(1'b1, `QVP_OFS_PWM, i << 20, 4'hF);
            repeat (3) @(posedge i_clk);
            chk({hs, ls}, i == 1 ? 4'h0 : i == 2 ? 4'h3 : 4'hC);
        end
        bus(1'b1, `QVP_OFS_CHOP, 32'h40, 4'hF);
        repeat (3) @(posedge i_clk);
        chk({hs, ls}, 4'h0);
        stand <= 1'b0;
        hzero <= 1'b0;
        bus(1'b1, `QVP_OFS_CHOP, 32'h41, 4'hF);
        for (i = 0; i < 4; i++) begin
            e = rnd();
            vel <= e[23:16];
            bus(1'b1, `QVP_OFS_PWM, 32'h30000 | e[15:0], 4'hF);
            gap();
            gap();
            repeat (3) @(posedge i_clk);
            chk(scale, fwd(e[7:0], e[15:8], e[23:16]));
            bus(1'b0, `QVP_OFS_STATUS, 32'h0, 4'h0);
            chk(q[10:0], 32'h500 | fwd(e[7:0], e[15:8], e[23:16]));
        end
        // duty steps from 0 to 0xC0: symmetric holds the old duty all
        // cycle, normal mode reloads it at the half point
        for (i = 0; i < 2; i++) begin
            bus(1'b1, `QVP_OFS_PWM, 32'h20000, 4'hF);
            gap();
            gap();
            bus(1'b1, `QVP_OFS_PWM, 32'h200C0 | ((1 - i) << 19), 4'hF);
            gap();
            e = 0;
            repeat (512) begin
                @(posedge i_clk);
                e += hs[0];
            end
            chk(e, i == 0 ? 0 : 128);
        end
        meas <= 8'h10;
        targ <= 8'h80;
        bus(1'b1, `QVP_OFS_PWM, 32'h30000, 4'hF);
        gap();
        gap();
        for (i = 0; i < 2; i++) begin
            bus(1'b1, `QVP_OFS_PWM, 32'h700FF | (i << 13), 4'hF);
            gap();
            repeat (3) @(posedge i_clk);
            s0 = scale;
            gap();
            repeat (3) @(posedge i_clk);
            chk(scale, s0 + (i == 0 ? 1 : 15));
            bus(1'b0, `QVP_OFS_STATUS, 32'h0, 4'h0);
            chk(q[9], 1'b1);
        end
        other <= 1'b1;
        repeat (3) @(posedge i_clk);
        s0 = scale;
        gap();
        gap();
        chk(scale, s0);
        other <= 1'b0;
        complete_run();
    end
endmodule
